// File: cdsc_defines.svh
`ifndef CDSC_DEFINES_SVH
`define CDSC_DEFINES_SVH

// Clock and derived timing
`define CDSC_CLK_NS         40
`define CDSC_TF_SETTLE_NS   4000000
`define CDSC_TF_SETTLE_CYC  ((`CDSC_TF_SETTLE_NS + `CDSC_CLK_NS - 1) / `CDSC_CLK_NS)
`define CDSC_TBUF_NS        4700
`define CDSC_TBUF_CYC       ((`CDSC_TBUF_NS + `CDSC_CLK_NS - 1) / `CDSC_CLK_NS)
`define CDSC_THIGH_MAX_NS   50000
`define CDSC_THIGH_MAX_CYC  (`CDSC_THIGH_MAX_NS / `CDSC_CLK_NS)
`define CDSC_SETTLE_W       17
`define CDSC_IDLE_W         11

// Serial register indices and reset values
`define CDSC_REG_ID         8'h00
`define CDSC_REG_STATUS     8'h01
`define CDSC_REG_MASK       8'h02
`define CDSC_REG_DIRECTION  8'h03
`define CDSC_REG_OUTPUT     8'h04
`define CDSC_ADDR_RESET     7'h17
`define CDSC_MASK_RESET     8'h00
`define CDSC_DIR_RESET      8'hc0
`define CDSC_OUTPUT_RESET   8'h90

// Field positions of mask and direction registers
`define CDSC_BIT_EDGE_SD    7
`define CDSC_BIT_PD         5
`define CDSC_BIT_TFN        2
`define CDSC_BIT_TFP        1
`define CDSC_BIT_LOS        0

// Serial byte framing
`define CDSC_BITS_PER_BYTE  4'h8

// Host-side AHB-Lite map
`define CDSC_AHB_CTRL       32'h0000_0000
`define CDSC_AHB_STATUS     32'h0000_0004
`define CDSC_CTRL_MUTE      0
`define CDSC_CTRL_LINK      1

`endif

// File: cdsc_pkg.sv
package cdsc_pkg;

	// Serial slave states, one-hot
	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_ADDR      = 10'h002,
		ST_ACK_ADDR  = 10'h004,
		ST_INDEX     = 10'h008,
		ST_ACK_INDEX = 10'h010,
		ST_DATA      = 10'h020,
		ST_ACK_DATA  = 10'h040,
		ST_SEND      = 10'h080,
		ST_HOST_ACK  = 10'h100,
		ST_IGNORE    = 10'h200
	} cdsc_state_t;

	// Inputs from outside the clock domain
	typedef struct packed {
		logic enable;
		logic chain_in;
		logic pattern;
		logic amp_hi_pos;
		logic amp_hi_neg;
		logic edge_pin;
		logic scl;
		logic sda;
	} cdsc_sense_t;

	// Serially programmed configuration
	typedef struct packed {
		logic [6:0] address;
		logic [7:0] mask;
		logic [7:0] direction;
		logic [7:0] output_level;
	} cdsc_cfg_t;

endpackage

// File: cdsc_sync.sv
`timescale 1ns/1ps

module cdsc_sync #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1;

	// Two flops; only the second reads the first
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// File: cdsc_top.sv
// Operation
// - Enable input low switches driver off and enters deep power save.
// - Signal present is flagged only when input shows a video-like pattern.
// - Programmable loss reaction: input offset or output mute; offset after reset.
// - Optional link drops internal enable while signal present is low.
// - Termination fault raised when amplitude high with signal; cleared when termination returns.
// - Termination fault detection only while driver on, valid after about 4 ms on.
// - Default bus address 17h; write byte 2Eh, read byte 2Fh.
// - Shared open-drain fault pin active on loss of signal or termination fault.
// - Each fault source can be masked off the fault pin.
// - Data falling with clock high is start; rising is stop.
// - Bus idle after bus-free time past stop, or clock-high maximum exceeded.
// - Data line stays stable while clock is high outside start and stop.
// - Write: address, index, data, stop; device acks each of three bytes.
// - Read: index write, repeated start, read address; device acks, returns one byte.
// - Chain reset output low after reset; low chain reset input holds reset.
// - Writing register 0 loads new address and raises chain reset output.
// - Programmed address is lost at power loss; host must reassign.
// - New address sits in bits seven to one of register 0.
// - Fault pin active low: unmasked fault drives it to zero.
// - Programmed edge rate applies only with pin low; high pin forces slow.
`timescale 1ns/1ps
`include "cdsc_defines.svh"

module cdsc_top import cdsc_pkg::*; #(
	parameter int TF_SETTLE_CYCLES = `CDSC_TF_SETTLE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        enable_pin,
	input  wire logic        chain_reset_in,
	input  wire logic        video_pattern,
	input  wire logic        amp_high_pos,
	input  wire logic        amp_high_neg,
	input  wire logic        edge_rate_select,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             fault_out,
	output logic             fault_oe,
	output logic             chain_reset_out,
	output logic             driver_on,
	output logic             power_save,
	output logic             input_offset,
	output logic             output_mute,
	output logic             edge_rate_slow,
	output logic [4:0]       amp_level,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp
);

	localparam int TBUF_CYC  = `CDSC_TBUF_CYC;
	localparam int THIGH_CYC = `CDSC_THIGH_MAX_CYC;

	cdsc_sense_t sense_raw;
	cdsc_sense_t sense_s;
	logic        scl_d, sda_d, dev_rst;
	logic        scl_rise, scl_fall, start_det, stop_det;

	////////////////////////////////////////////////////////////////////////////
	// Input crossing and bus edge detection

	assign sense_raw = '{enable: enable_pin, chain_in: chain_reset_in,
		pattern: video_pattern, amp_hi_pos: amp_high_pos, amp_hi_neg: amp_high_neg,
		edge_pin: edge_rate_select, scl: scl_in, sda: sda_in};

	cdsc_sync #(.W($bits(cdsc_sense_t))) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (sense_raw),
		.sync_out (sense_s)
	);

	// Delayed copies for edges; device reset follows chain input
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
			dev_rst <= 1'b1;
		end else begin
			scl_d   <= sense_s.scl;
			sda_d   <= sense_s.sda;
			dev_rst <= ~sense_s.chain_in;
		end
	end

	assign scl_rise  = sense_s.scl & ~scl_d;
	assign scl_fall  = ~sense_s.scl & scl_d;
	assign start_det = sense_s.scl & scl_d & sda_d & ~sense_s.sda;
	assign stop_det  = sense_s.scl & scl_d & ~sda_d & sense_s.sda;

	////////////////////////////////////////////////////////////////////////////
	// Serial slave and its registers

	cdsc_state_t state, next_state;
	cdsc_cfg_t   cfg, next_cfg;
	logic [3:0]  bit_cnt, next_bit_cnt;
	logic [7:0]  shreg, next_shreg, index, next_index;
	logic        rd_mode, next_rd_mode, next_sda_oe, next_chain_out;
	logic        sig_present, tf_pos, tf_neg;
	logic [7:0]  rd_byte;

	function automatic logic [7:0] read_reg(input logic [7:0] idx, input cdsc_cfg_t c,
		input logic [2:0] st);
		if (idx == `CDSC_REG_ID)
			read_reg = {c.address, 1'b0};
		else if (idx == `CDSC_REG_STATUS)
			read_reg = {5'h00, st};
		else if (idx == `CDSC_REG_MASK)
			read_reg = c.mask;
		else if (idx == `CDSC_REG_DIRECTION)
			read_reg = c.direction;
		else if (idx == `CDSC_REG_OUTPUT)
			read_reg = c.output_level;
		else
			read_reg = 8'h00;
	endfunction

	assign rd_byte = read_reg(index, cfg, {tf_neg, tf_pos, sig_present});

	// Byte framing; the drive changes only on a clock fall so data is stable while high
	always_comb begin
		next_state     = state;
		next_cfg       = cfg;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_index     = index;
		next_rd_mode   = rd_mode;
		next_sda_oe    = sda_oe;
		next_chain_out = chain_reset_out;
		if (start_det) begin
			next_state   = ST_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe  = 1'b0;
		end else if (stop_det) begin
			next_state  = ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_INDEX, ST_DATA: begin
					if (scl_rise) begin
						next_shreg   = {shreg[6:0], sense_s.sda};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `CDSC_BITS_PER_BYTE) begin
						next_bit_cnt = 4'h0;
						next_sda_oe  = 1'b1;
						if (state == ST_ADDR) begin
							if (shreg[7:1] == cfg.address) begin
								next_state   = ST_ACK_ADDR;
								next_rd_mode = shreg[0];
							end else begin
								next_state  = ST_IGNORE;
								next_sda_oe = 1'b0;
							end
						end else if (state == ST_INDEX) begin
							next_index = shreg;
							next_state = ST_ACK_INDEX;
						end else begin
							next_state = ST_ACK_DATA;
							if (index == `CDSC_REG_ID) begin
								next_cfg.address = shreg[7:1];
								next_chain_out   = 1'b1;
							end else if (index == `CDSC_REG_MASK) begin
								next_cfg.mask = shreg;
							end else if (index == `CDSC_REG_DIRECTION) begin
								next_cfg.direction = shreg;
							end else if (index == `CDSC_REG_OUTPUT) begin
								next_cfg.output_level = shreg;
							end
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						if (rd_mode) begin
							next_state   = ST_SEND;
							next_shreg   = rd_byte;
							next_bit_cnt = 4'h1;
							next_sda_oe  = ~rd_byte[7];
						end else begin
							next_state  = ST_INDEX;
							next_sda_oe = 1'b0;
						end
					end
				end
				ST_ACK_INDEX: begin
					if (scl_fall) begin
						next_state  = ST_DATA;
						next_sda_oe = 1'b0;
					end
				end
				ST_ACK_DATA: begin
					// One data byte per write; later bytes are not acknowledged
					if (scl_fall) begin
						next_state  = ST_IGNORE;
						next_sda_oe = 1'b0;
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == `CDSC_BITS_PER_BYTE) begin
							next_state  = ST_HOST_ACK;
							next_sda_oe = 1'b0;
						end else begin
							next_shreg   = {shreg[6:0], 1'b0};
							next_sda_oe  = ~shreg[6];
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				ST_HOST_ACK: begin
					// Single-byte reads only; ack or nack both end the data
					if (scl_fall)
						next_state = ST_IGNORE;
				end
				default: begin
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Nothing programmed survives a reset of the device
	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			state           <= ST_IDLE;
			cfg             <= '{address: `CDSC_ADDR_RESET, mask: `CDSC_MASK_RESET,
				direction: `CDSC_DIR_RESET, output_level: `CDSC_OUTPUT_RESET};
			bit_cnt         <= 4'h0;
			shreg           <= 8'h00;
			index           <= 8'h00;
			rd_mode         <= 1'b0;
			sda_oe          <= 1'b0;
			sda_out         <= 1'b0;
			chain_reset_out <= 1'b0;
		end else begin
			state           <= next_state;
			cfg             <= next_cfg;
			bit_cnt         <= next_bit_cnt;
			shreg           <= next_shreg;
			index           <= next_index;
			rd_mode         <= next_rd_mode;
			sda_oe          <= next_sda_oe;
			sda_out         <= 1'b0;
			chain_reset_out <= next_chain_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Signal, termination and fault pin

	logic [`CDSC_SETTLE_W-1:0] on_cnt, next_on_cnt;
	logic [`CDSC_IDLE_W-1:0]   high_cnt, next_high_cnt;
	logic                      seen_stop, next_seen_stop, bus_idle, next_bus_idle;
	logic                      ctrl_mute, ctrl_link, enable_int, drive_en, settled;
	logic                      los_f, tfp_f, tfn_f;
	logic                      next_tf_pos, next_tf_neg;

	assign enable_int = sense_s.enable & ~(ctrl_link & ~sense_s.pattern);
	assign drive_en   = enable_int & ~cfg.mask[`CDSC_BIT_PD];
	assign settled    = on_cnt >= `CDSC_SETTLE_W'(TF_SETTLE_CYCLES);

	// Direction flips the active sense of each source before its mask
	assign los_f = (cfg.direction[`CDSC_BIT_LOS] ? sig_present : ~sig_present)
		& ~cfg.mask[`CDSC_BIT_LOS];
	assign tfp_f = (cfg.direction[`CDSC_BIT_TFP] ? ~tf_pos : tf_pos)
		& ~cfg.mask[`CDSC_BIT_TFP];
	assign tfn_f = (cfg.direction[`CDSC_BIT_TFN] ? ~tf_neg : tf_neg)
		& ~cfg.mask[`CDSC_BIT_TFN];

	always_comb begin
		next_on_cnt    = drive_en ? (settled ? on_cnt : on_cnt + `CDSC_SETTLE_W'(1))
			: '0;
		next_tf_pos    = settled & drive_en & sense_s.pattern & sense_s.amp_hi_pos;
		next_tf_neg    = settled & drive_en & sense_s.pattern & sense_s.amp_hi_neg;
		next_seen_stop = stop_det ? 1'b1 : (start_det ? 1'b0 : seen_stop);
		next_high_cnt  = high_cnt;
		next_bus_idle  = bus_idle;
		if (!(sense_s.scl && sense_s.sda) || stop_det)
			next_high_cnt = '0;
		else if (high_cnt != `CDSC_IDLE_W'(THIGH_CYC))
			next_high_cnt = high_cnt + `CDSC_IDLE_W'(1);
		if (start_det)
			next_bus_idle = 1'b0;
		else if ((seen_stop && high_cnt >= `CDSC_IDLE_W'(TBUF_CYC))
			|| high_cnt == `CDSC_IDLE_W'(THIGH_CYC))
			next_bus_idle = 1'b1;
	end

	// Analog detector already rejects oscillation and noise; here it is only sampled
	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			on_cnt         <= '0;
			tf_pos         <= 1'b0;
			tf_neg         <= 1'b0;
			sig_present    <= 1'b0;
			seen_stop      <= 1'b0;
			high_cnt       <= '0;
			bus_idle       <= 1'b1;
			fault_out      <= 1'b0;
			fault_oe       <= 1'b0;
			driver_on      <= 1'b0;
			power_save     <= 1'b1;
			input_offset   <= 1'b0;
			output_mute    <= 1'b0;
			edge_rate_slow <= 1'b1;
			amp_level      <= 5'h00;
		end else begin
			on_cnt         <= next_on_cnt;
			tf_pos         <= next_tf_pos;
			tf_neg         <= next_tf_neg;
			sig_present    <= sense_s.pattern;
			seen_stop      <= next_seen_stop;
			high_cnt       <= next_high_cnt;
			bus_idle       <= next_bus_idle;
			fault_out      <= 1'b0;
			fault_oe       <= los_f | tfp_f | tfn_f;
			driver_on      <= drive_en;
			power_save     <= ~enable_int;
			input_offset   <= ~sense_s.pattern & ~ctrl_mute;
			output_mute    <= ~sense_s.pattern & ctrl_mute;
			edge_rate_slow <= sense_s.edge_pin | cfg.mask[`CDSC_BIT_EDGE_SD];
			amp_level      <= cfg.output_level[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY

	logic        ap_valid, ap_write, next_ap_valid, next_ap_write;
	logic [31:0] ap_addr, next_ap_addr, next_hrdata;
	logic        next_ctrl_mute, next_ctrl_link;

	always_comb begin
		next_ap_valid  = hsel & hready & htrans[1];
		next_ap_write  = hwrite;
		next_ap_addr   = haddr;
		next_ctrl_mute = ctrl_mute;
		next_ctrl_link = ctrl_link;
		next_hrdata    = 32'h0000_0000;
		// Write data lands in the data phase
		if (ap_valid && ap_write && ap_addr == `CDSC_AHB_CTRL) begin
			next_ctrl_mute = hwdata[`CDSC_CTRL_MUTE];
			next_ctrl_link = hwdata[`CDSC_CTRL_LINK];
		end
		// Read data is registered in the address phase; unmapped reads give zero
		if (next_ap_valid && !hwrite) begin
			if (haddr == `CDSC_AHB_CTRL)
				next_hrdata = {30'h0000_0000, next_ctrl_link, next_ctrl_mute};
			else if (haddr == `CDSC_AHB_STATUS)
				next_hrdata = {17'h0_0000, cfg.address, 2'b00, bus_idle, chain_reset_out,
					driver_on, tf_neg, tf_pos, sig_present};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			ap_valid  <= 1'b0;
			ap_write  <= 1'b0;
			ap_addr   <= 32'h0000_0000;
			ctrl_mute <= 1'b0;
			ctrl_link <= 1'b0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_valid  <= next_ap_valid;
			ap_write  <= next_ap_write;
			ap_addr   <= next_ap_addr;
			ctrl_mute <= next_ctrl_mute;
			ctrl_link <= next_ctrl_link;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (dev_rst);

	sequence s_byte_end;
		scl_fall && !start_det && !stop_det && bit_cnt == `CDSC_BITS_PER_BYTE;
	endsequence

	sequence s_addr_hit;
		state == ST_ADDR && shreg[7:1] == cfg.address;
	endsequence

	a_power_save_off: assert property (!sense_s.enable |=> power_save && !driver_on)
		else $error("driver left on with enable low");
	a_signal_flag: assert property (sense_s.pattern |=> sig_present)
		else $error("signal present not flagged");
	a_los_reaction: assert property (!sense_s.pattern |=> input_offset != output_mute)
		else $error("loss reaction not exclusive");
	a_los_link: assert property (ctrl_link && !sense_s.pattern |=> power_save)
		else $error("linked enable did not drop");
	a_tf_settle: assert property ($rose(tf_pos) |-> driver_on && settled)
		else $error("termination fault before settle");
	a_fault_pin: assert property ((los_f || tfp_f || tfn_f) |=> fault_oe && !fault_out)
		else $error("fault pin not driven low");
	a_mask_all: assert property (cfg.mask[2:0] == 3'h7 |=> !fault_oe)
		else $error("masked fault reached pin");
	a_start_addr: assert property (start_det |=> state == ST_ADDR && !sda_oe)
		else $error("start not recognised");
	a_addr_ack: assert property (s_addr_hit ##0 s_byte_end
		|=> state == ST_ACK_ADDR && sda_oe)
		else $error("address not acknowledged");
	// Ack must stand until the host's next clock fall ends the ninth bit
	a_ack_hold: assert property (state == ST_ACK_ADDR && !scl_fall && !start_det
		&& !stop_det |=> sda_oe)
		else $error("acknowledge dropped early");
	a_addr_miss: assert property (state == ST_ADDR && shreg[7:1] != cfg.address ##0 s_byte_end
		|=> state == ST_IGNORE && !sda_oe)
		else $error("foreign address answered");
	a_id_write: assert property (state == ST_DATA && index == `CDSC_REG_ID ##0 s_byte_end
		|=> chain_reset_out && cfg.address == $past(shreg[7:1]))
		else $error("id write failed");
	a_chain_low: assert property (!chain_reset_out |-> $past(chain_reset_out, 1) == 1'b0
		|| $past(dev_rst))
		else $error("chain reset out fell without reset");
	a_idle_max: assert property (high_cnt == `CDSC_IDLE_W'(THIGH_CYC) && !start_det
		|=> bus_idle)
		else $error("bus not idle after clock high limit");
	a_edge_pin: assert property (sense_s.edge_pin |=> edge_rate_slow)
		else $error("edge pin did not force slow rate");

endmodule

// File: cdsc_host_model.sv
`timescale 1ns/1ps

module cdsc_host_model (
	input  wire logic sys_clk,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low,
	output logic      host_general_output
);

	// Bus released and downstream chain held in reset at power-up
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		host_general_output     = 1'b0;
	end

	////////////////////////////////////////
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Drives the host reset line to the first device
	task automatic set_chain(input logic v);
		host_general_output <= v;
	endtask

	// One bit; data moves only mid-low so the device never sees a false frame
	task automatic bit_io(input logic b, output logic s);
		scl_low <= 1'b1;
		hw(2);
		sda_low <= ~b;
		hw(2);
		scl_low <= 1'b0;
		hw(3);
		s = sda;
		hw(1);
	endtask

	// Start when st is high, stop otherwise; clock stands high after a stop
	task automatic frame(input logic st);
		scl_low <= 1'b1;
		hw(2);
		sda_low <= ~st;
		hw(2);
		scl_low <= 1'b0;
		hw(4);
		sda_low <= st;
		hw(4);
	endtask

	// Eight bits, then the line is released for the ninth (ack in, or host NACK)
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, ack);
	endtask

	task automatic wr_reg(input logic [6:0] a, input logic [7:0] idx, d, output logic [2:0] k);
		logic [7:0] q;
		frame(1'b1);
		byte_io({a, 1'b0}, q, k[2]);
		byte_io(idx, q, k[1]);
		byte_io(d, q, k[0]);
		frame(1'b0);
	endtask

	task automatic rd_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] q,
			output logic [2:0] k);
		logic [7:0] x;
		frame(1'b1);
		byte_io({a, 1'b0}, x, k[2]);
		byte_io(idx, x, k[1]);
		frame(1'b1);
		byte_io({a, 1'b1}, x, k[0]);
		byte_io(8'hff, q, x[0]);
		frame(1'b0);
	endtask

endmodule

// File: cdsc_top_tb.sv
`timescale 1ns/1ps
`include "cdsc_defines.svh"

module cdsc_top_tb import cdsc_pkg::*;;
	logic        sys_clk, rst, enable_pin, video_pattern;
	logic        amp_high_pos, amp_high_neg, edge_rate_select;
	logic        hsel, hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, rdv;
	logic [2:0]  ak;
	logic [7:0]  q;
	wire         chain_reset_in, scl_low, sda_low, sda_out, sda_oe, fault_out, fault_oe;
	wire         chain_reset_out, driver_on, power_save, input_offset, output_mute;
	wire         edge_rate_slow, hreadyout, hresp, hready, scl_in, sda_in;
	wire [4:0]   amp_level;
	wire [31:0]  hrdata;
	int          error_cnt, tests_run;

	// Open-drain wires with pull-ups
	assign scl_in = ~scl_low;
	assign sda_in = ~(sda_low | (sda_oe & ~sda_out));
	assign hready = hreadyout;

	cdsc_top #(.TF_SETTLE_CYCLES(20)) i_cdsc_top (
		.sys_clk(sys_clk), .rst(rst), .enable_pin(enable_pin),
		.chain_reset_in(chain_reset_in), .video_pattern(video_pattern),
		.amp_high_pos(amp_high_pos), .amp_high_neg(amp_high_neg),
		.edge_rate_select(edge_rate_select), .scl_in(scl_in), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .fault_out(fault_out), .fault_oe(fault_oe),
		.chain_reset_out(chain_reset_out), .driver_on(driver_on), .power_save(power_save),
		.input_offset(input_offset), .output_mute(output_mute),
		.edge_rate_slow(edge_rate_slow), .amp_level(amp_level), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

	cdsc_host_model i_cdsc_host_model (
		.sys_clk(sys_clk), .sda(sda_in), .scl_low(scl_low), .sda_low(sda_low),
		.host_general_output(chain_reset_in));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Bounded wait for ready; a hang ends the run
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			close_out();
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		hwait();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		hwait();
		rdv = hrdata;
	endtask

	task automatic mask(input logic [7:0] v);
		i_cdsc_host_model.wr_reg(7'h16, `CDSC_REG_MASK, v, ak);
		wc(6);
	endtask

	////////////////////////////////////////
	task automatic t_ahb();
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("bus address", 32'h17, 32'(rdv[14:8]));
		ahb(1'b1, `CDSC_AHB_CTRL, 32'h3);
		ahb(1'b0, `CDSC_AHB_CTRL, 32'h0);
		chk("ctrl", 32'h3, rdv);
		ahb(1'b1, `CDSC_AHB_CTRL, 32'h0);
		ahb(1'b0, 32'h8, 32'h0);
		chk("unmapped", 32'h0, rdv);
		chk("hresp", 32'h0, hresp);
	endtask

	// Address hand-off, then foreign address ignored, then read back
	task automatic t_addr();
		i_cdsc_host_model.wr_reg(7'h17, `CDSC_REG_ID, 8'h2c, ak);
		chk("write acks", 32'h0, ak);
		chk("chain out", 32'h1, chain_reset_out);
		wc(130);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("new address", 32'h2c >> 1, 32'(rdv[14:8]));
		chk("bus idle", 32'h1, rdv[5]);
		i_cdsc_host_model.wr_reg(7'h17, `CDSC_REG_MASK, 8'h21, ak);
		chk("foreign acks", 32'h7, ak);
		i_cdsc_host_model.rd_reg(7'h16, `CDSC_REG_MASK, q, ak);
		chk("read acks", 32'h0, ak);
		chk("mask kept", 32'h0, q);
		i_cdsc_host_model.rd_reg(7'h16, `CDSC_REG_ID, q, ak);
		chk("id read", 32'h2c, q);
	endtask

	task automatic t_enable();
		enable_pin <= 1'b0;
		wc(6);
		chk("driver off", 32'h0, driver_on);
		chk("power save", 32'h1, power_save);
		enable_pin <= 1'b1;
		wc(6);
		chk("driver on", 32'h1, driver_on);
		chk("awake", 32'h0, power_save);
	endtask

	task automatic t_los();
		video_pattern <= 1'b0;
		wc(6);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("signal", 32'h0, rdv[0]);
		chk("los fault", 32'h1, fault_oe);
		chk("fault level", 32'h0, fault_out);
		chk("offset", 32'h1, input_offset);
		mask(8'h01);
		chk("los masked", 32'h0, fault_oe);
		mask(8'h00);
		ahb(1'b1, `CDSC_AHB_CTRL, 32'h1);
		wc(4);
		chk("mute", 32'h1, output_mute);
		chk("no offset", 32'h0, input_offset);
		ahb(1'b1, `CDSC_AHB_CTRL, 32'h2);
		wc(6);
		chk("linked off", 32'h0, driver_on);
		ahb(1'b1, `CDSC_AHB_CTRL, 32'h0);
		video_pattern <= 1'b1;
		wc(6);
		chk("no fault", 32'h0, fault_oe);
		i_cdsc_host_model.rd_reg(7'h16, `CDSC_REG_STATUS, q, ak);
		chk("serial status", 32'h1, q);
		i_cdsc_host_model.wr_reg(7'h16, `CDSC_REG_DIRECTION, 8'hc1, ak);
		chk("los sense", 32'h1, fault_oe);
		i_cdsc_host_model.wr_reg(7'h16, `CDSC_REG_DIRECTION, `CDSC_DIR_RESET, ak);
		chk("sense back", 32'h0, fault_oe);
	endtask

	// Recheck after a power-down cycle; result must wait for the settle time
	task automatic t_tf();
		amp_high_pos <= 1'b1;
		enable_pin   <= 1'b0;
		wc(6);
		enable_pin <= 1'b1;
		wc(8);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("tf early", 32'h0, rdv[1]);
		wc(30);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("tf pos", 32'h1, rdv[1]);
		chk("tf fault", 32'h1, fault_oe);
		mask(8'h02);
		chk("tf masked", 32'h0, fault_oe);
		mask(8'h07);
		chk("all masked", 32'h0, fault_oe);
		mask(8'h00);
		amp_high_pos <= 1'b0;
		amp_high_neg <= 1'b1;
		wc(6);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("tf neg", 32'h2, 32'(rdv[2:1]));
		amp_high_neg <= 1'b0;
		wc(6);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("tf clear", 32'h0, 32'(rdv[2:1]));
		chk("fault gone", 32'h0, fault_oe);
	endtask

	task automatic t_edge();
		edge_rate_select <= 1'b1;
		mask(8'h00);
		chk("pin slow", 32'h1, edge_rate_slow);
		edge_rate_select <= 1'b0;
		wc(6);
		chk("fast", 32'h0, edge_rate_slow);
		mask(8'h80);
		chk("reg slow", 32'h1, edge_rate_slow);
		mask(8'h00);
	endtask

	// Lines left high after a start with no stop reach idle by the clock-high limit
	task automatic t_idle();
		logic b;
		i_cdsc_host_model.frame(1'b1);
		i_cdsc_host_model.bit_io(1'b1, b);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("bus busy", 32'h0, rdv[5]);
		wc(1260);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("idle on high", 32'h1, rdv[5]);
		i_cdsc_host_model.frame(1'b0);
	endtask

	task automatic t_chain();
		i_cdsc_host_model.set_chain(1'b0);
		wc(6);
		chk("chain held", 32'h0, chain_reset_out);
		i_cdsc_host_model.set_chain(1'b1);
		wc(6);
		ahb(1'b0, `CDSC_AHB_STATUS, 32'h0);
		chk("address lost", 32'h17, 32'(rdv[14:8]));
	endtask

	////////////////////////////////////////
	initial begin
		rst              = 1'b1;
		enable_pin       = 1'b1;
		video_pattern    = 1'b1;
		amp_high_pos     = 1'b0;
		amp_high_neg     = 1'b0;
		edge_rate_select = 1'b0;
		hsel             = 1'b0;
		hwrite           = 1'b0;
		htrans           = 2'b00;
		hsize            = 3'b010;
		haddr            = 32'h0;
		hwdata           = 32'h0;
		error_cnt        = 0;
		tests_run        = 0;
		wc(6);
		rst <= 1'b0;
		wc(6);
		chk("chain reset", 32'h0, chain_reset_out);
		chk("held save", 32'h1, power_save);
		i_cdsc_host_model.set_chain(1'b1);
		wc(6);
		chk("amp level", 32'h10, amp_level);
		t_ahb();
		t_addr();
		t_enable();
		t_los();
		t_tf();
		t_edge();
		t_idle();
		t_chain();
		close_out();
	end

endmodule
